/* File: logic/irh_cfg.svh */
`ifndef IRH_CFG_SVH
`define IRH_CFG_SVH
// Fixed table slot for the non-maskable request
`define IRH_NMI_SLOT        8'h02
// Least reset hold in clock periods, plain and with self-test
`define IRH_RESET_MIN       8'd15
`define IRH_RESET_SELFTEST  8'd80
// Vector width of the maskable acknowledge answer
`define IRH_VEC_W           8
`endif

/* File: logic/irh_pkg.sv */
package irh_pkg;
   // Sequencer states
   typedef enum logic [2:0] {
      IRH_IDLE,
      IRH_SAVE,
      IRH_ACK1,
      IRH_ACK2,
      IRH_FETCH
   } irh_state_e;
endpackage

/* File: logic/irh_sync.sv */
`timescale 1ns/1ps
// ****************************************
// Two-stage synchroniser
// ****************************************
module irh_sync
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic nrst_i,
   // Data
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_reg;
   logic q_reg;

   // First stage read only by the second
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         meta_reg <= 1'b0;
         q_reg    <= 1'b0;
      end
      else
      begin
         meta_reg <= d_i;
         q_reg    <= meta_reg;
      end
   end

   assign q_o = q_reg;
endmodule

/* File: logic/irh_top.sv */
`timescale 1ns/1ps
`include "irh_cfg.svh"
module irh_top
(
   // Clock and power-on reset
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   // Pin-level requests
   input  wire logic        nmi_i,
   input  wire logic        maskable_request_i,
   input  wire logic        reset_i,
   input  wire logic        bus_request_i,
   input  wire logic        cop_wait_n_i,
   // Execution unit status
   input  wire logic        boundary_i,
   input  wire logic        string_iter_i,
   input  wire logic        ss_load_i,
   input  wire logic        sti_i,
   input  wire logic        if_flag_i,
   input  wire logic        interrupt_return_instruction_i,
   // Bus side handshake
   input  wire logic        cycle_done_i,
   input  wire logic [7:0]  data_low_i,
   // Outputs
   output logic             bus_grant_output_o,
   output logic             take_o,
   output logic             save_state_o,
   output logic             ack_cycle_o,
   output logic             vec_valid_o,
   output logic [7:0]       vector_o,
   output logic             in_reset_o,
   output logic             selftest_o
);
   logic nmi_s, maskable_request_s, rst_s, hold_s, busy_n_s;
   logic nmi_d_reg, nmi_d_next;
   logic inserv_reg, inserv_next;
   logic pend_reg, pend_next;
   logic shadow_reg, shadow_next;
   logic grant_reg, grant_next;
   logic take_reg, take_next;
   logic save_reg, save_next;
   logic ack_reg, ack_next;
   logic vv_reg, vv_next;
   logic [7:0] vec_reg, vec_next;
   logic rst_d_reg;
   logic st_reg, st_next;
   logic is_nmi_reg, is_nmi_next;
   irh_pkg::irh_state_e state_reg, state_next;
   logic nmi_rise, point, nmi_go, maskable_request_go;

   // ****************************************
   // Input synchronisers
   // ****************************************
   irh_sync u_s_nmi (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(nmi_i), .q_o(nmi_s));
   irh_sync u_s_int (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(maskable_request_i), .q_o(maskable_request_s));
   irh_sync u_s_rst (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(reset_i), .q_o(rst_s));
   irh_sync u_s_hld (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(bus_request_i), .q_o(hold_s));
   irh_sync u_s_bsy (.clk_i(clk_i), .nrst_i(nrst_i), .d_i(cop_wait_n_i), .q_o(busy_n_s));

   // ****************************************
   // Recognition
   // ****************************************
   // Edge, not level, so a held line fires once
   assign nmi_rise = nmi_s && !nmi_d_reg;
   // Recognition point: a boundary, or a string iteration outside a shadow; the boundary
   // that ends a stack segment load or flag set is skipped, so one more instruction runs
   assign point   = (boundary_i || (string_iter_i && !shadow_reg))
                    && !ss_load_i && !sti_i && !grant_reg;
   assign nmi_go  = point && pend_reg && !inserv_reg;
   assign maskable_request_go = point && !nmi_go && maskable_request_s && if_flag_i;

   // Next-state logic
   always_comb
   begin
      nmi_d_next  = nmi_s;
      inserv_next = inserv_reg;
      pend_next   = pend_reg;
      shadow_next = shadow_reg;
      grant_next  = hold_s && state_reg == irh_pkg::IRH_IDLE;
      take_next   = 1'b0;
      save_next   = 1'b0;
      ack_next    = 1'b0;
      vv_next     = 1'b0;
      vec_next    = vec_reg;
      st_next     = st_reg;
      is_nmi_next = is_nmi_reg;
      state_next  = state_reg;
      // One remembered edge, also across bus grant
      if (nmi_rise)
         pend_next = 1'b1;
      if (interrupt_return_instruction_i)
         inserv_next = 1'b0;
      // Shadow keeps iterations out until the following instruction ends
      if (ss_load_i || sti_i)
         shadow_next = 1'b1;
      else if (boundary_i)
         shadow_next = 1'b0;
      case (state_reg)
         irh_pkg::IRH_IDLE:
         begin
            if (nmi_go || maskable_request_go)
            begin
               take_next   = 1'b1;
               save_next   = 1'b1;
               is_nmi_next = nmi_go;
               state_next  = irh_pkg::IRH_SAVE;
               if (nmi_go)
               begin
                  inserv_next = 1'b1;
                  pend_next   = nmi_rise;
               end
            end
         end
         irh_pkg::IRH_SAVE:
         begin
            save_next = !cycle_done_i;
            if (cycle_done_i)
            begin
               if (is_nmi_reg)
               begin
                  vec_next   = `IRH_NMI_SLOT;
                  vv_next    = 1'b1;
                  state_next = irh_pkg::IRH_FETCH;
               end
               else
               begin
                  ack_next   = 1'b1;
                  state_next = irh_pkg::IRH_ACK1;
               end
            end
         end
         irh_pkg::IRH_ACK1:
         begin
            ack_next = 1'b1;
            if (cycle_done_i)
               state_next = irh_pkg::IRH_ACK2;
         end
         irh_pkg::IRH_ACK2:
         begin
            ack_next = !cycle_done_i;
            if (cycle_done_i)
            begin
               vec_next   = data_low_i;
               vv_next    = 1'b1;
               state_next = irh_pkg::IRH_FETCH;
            end
         end
         default:
            state_next = irh_pkg::IRH_IDLE;
      endcase
      // Reset wins over everything, grant included
      if (rst_s)
      begin
         inserv_next = 1'b0;
         pend_next   = 1'b0;
         shadow_next = 1'b0;
         grant_next  = 1'b0;
         take_next   = 1'b0;
         save_next   = 1'b0;
         ack_next    = 1'b0;
         vv_next     = 1'b0;
         vec_next    = 8'h00;
         state_next  = irh_pkg::IRH_IDLE;
         st_next     = 1'b0;
      end
      else if (rst_d_reg)
         st_next = !busy_n_s;
   end

   // Registers
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         nmi_d_reg  <= 1'b0;
         inserv_reg <= 1'b0;
         pend_reg   <= 1'b0;
         shadow_reg <= 1'b0;
         grant_reg  <= 1'b0;
         take_reg   <= 1'b0;
         save_reg   <= 1'b0;
         ack_reg    <= 1'b0;
         vv_reg     <= 1'b0;
         vec_reg    <= 8'h00;
         rst_d_reg  <= 1'b0;
         st_reg     <= 1'b0;
         is_nmi_reg <= 1'b0;
         state_reg  <= irh_pkg::IRH_IDLE;
      end
      else
      begin
         nmi_d_reg  <= nmi_d_next;
         inserv_reg <= inserv_next;
         pend_reg   <= pend_next;
         shadow_reg <= shadow_next;
         grant_reg  <= grant_next;
         take_reg   <= take_next;
         save_reg   <= save_next;
         ack_reg    <= ack_next;
         vv_reg     <= vv_next;
         vec_reg    <= vec_next;
         rst_d_reg  <= rst_s;
         st_reg     <= st_next;
         is_nmi_reg <= is_nmi_next;
         state_reg  <= state_next;
      end
   end

   assign bus_grant_output_o = grant_reg;
   assign take_o             = take_reg;
   assign save_state_o       = save_reg;
   assign ack_cycle_o        = ack_reg;
   assign vec_valid_o        = vv_reg;
   assign vector_o           = vec_reg;
   assign in_reset_o         = rst_d_reg;
   assign selftest_o         = st_reg;

   // ****************************************
   // Assertions
   // ****************************************
   a_nmi_no_ack: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (state_reg == irh_pkg::IRH_SAVE && is_nmi_reg) |=> !ack_reg) else $error("ack during nmi");
   a_nmi_slot: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (vv_reg && is_nmi_reg) |-> vec_reg == `IRH_NMI_SLOT) else $error("nmi slot wrong");
   a_nmi_block: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (inserv_reg && !interrupt_return_instruction_i && !rst_s) |=> inserv_reg) else $error("nmi unblocked early");
   a_edge_pend: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (nmi_rise && !rst_s) |=> pend_reg) else $error("edge lost");
   a_maskable_request_mask: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (state_reg == irh_pkg::IRH_IDLE && !if_flag_i && !pend_reg && !rst_s) |=> !take_reg)
      else $error("masked request taken");
   a_shadow_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ((sti_i || ss_load_i) && !rst_s) |=> !take_reg) else $error("shadow violated");
   a_shadow_iter: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (shadow_reg && string_iter_i && !boundary_i && !rst_s) |=> !take_reg)
      else $error("iteration taken in shadow");
   a_reset_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rst_s |=> (!take_reg && !ack_reg && !grant_reg && !save_reg)) else $error("not idle in reset");
   a_reset_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rst_s |=> (!pend_reg && !inserv_reg)) else $error("nmi state not cleared");
   a_two_acks: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (state_reg == irh_pkg::IRH_ACK2 && cycle_done_i && !rst_s) |=> (vv_reg && vec_reg == $past(data_low_i)))
      else $error("vector not latched");
   c_nmi: cover property (@(posedge clk_i) disable iff (!nrst_i) take_reg && is_nmi_reg);
   c_maskable_request: cover property (@(posedge clk_i) disable iff (!nrst_i) vv_reg && !is_nmi_reg);
   c_pend_blocked: cover property (@(posedge clk_i) disable iff (!nrst_i) nmi_rise && inserv_reg);
endmodule

/* File: sim/irh_src.sv */
`timescale 1ns/1ps
// ****************************************
// Interrupt and reset sources
// ****************************************
module irh_src
(
   // Clock
   input  wire logic clk_i,
   // Answer seen from the device
   input  wire logic take_i,
   // Requests
   output logic      nmi_o,
   output logic      mreq_o,
   output logic      reset_o
);
   // Quiet levels from time zero
   initial
   begin
      nmi_o   = 1'b0;
      mreq_o  = 1'b0;
      reset_o = 1'b0;
   end
   // Level request kept up until taken, so it cannot be missed
   always @(negedge clk_i)
   begin
      if (take_i === 1'b1)
         mreq_o <= 1'b0;
   end
   // Low then high, eight periods each, so the edge is always seen
   task automatic nmi_edge();
   begin
      nmi_o = 1'b0;
      repeat (8) @(negedge clk_i);
      nmi_o = 1'b1;
      repeat (8) @(negedge clk_i);
   end
   endtask
   // Reset level held n periods, changed away from the sampling edge
   task automatic pulse_reset(input int n);
   begin
      reset_o = 1'b1;
      repeat (n) @(negedge clk_i);
      reset_o = 1'b0;
   end
   endtask
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
   // ****************************************
   // Signals and bench model state
   // ****************************************
   logic       clk_i, nrst_i, bus_request_i, cop_wait_n_i, boundary_i, string_iter_i;
   logic       ss_load_i, sti_i, if_flag_i, interrupt_return_instruction_i, cycle_done_i;
   logic [7:0] data_low_i, vector_o;
   logic       nmi_w, mreq_w, rst_w, grant_o, take_o, save_state_o, ack_cycle_o, vec_valid_o, in_reset_o, selftest_o;
   int         fail_count, samples_checked, takes, acks, saves, vecs, t0, a0, j, k;
   logic [7:0] exp_q[$];

   irh_src src_u (.clk_i(clk_i), .take_i(take_o), .nmi_o(nmi_w), .mreq_o(mreq_w), .reset_o(rst_w));
   irh_top dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .nmi_i(nmi_w), .maskable_request_i(mreq_w), .reset_i(rst_w),
      .bus_request_i(bus_request_i), .cop_wait_n_i(cop_wait_n_i), .boundary_i(boundary_i),
      .string_iter_i(string_iter_i), .ss_load_i(ss_load_i), .sti_i(sti_i), .if_flag_i(if_flag_i),
      .interrupt_return_instruction_i(interrupt_return_instruction_i), .cycle_done_i(cycle_done_i), .data_low_i(data_low_i), .bus_grant_output_o(grant_o),
      .take_o(take_o), .save_state_o(save_state_o), .ack_cycle_o(ack_cycle_o), .vec_valid_o(vec_valid_o),
      .vector_o(vector_o), .in_reset_o(in_reset_o), .selftest_o(selftest_o));

   // 20 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
   begin
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   end
   endtask
   task automatic close_out();
   begin
      if (fail_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   // One status pulse {interrupt_return_instruction, boundary, string, ss load, sti}, then three quiet periods
   task automatic step(input logic [4:0] f);
   begin
      {interrupt_return_instruction_i, boundary_i, string_iter_i, ss_load_i, sti_i} = f;
      @(negedge clk_i);
      {interrupt_return_instruction_i, boundary_i, string_iter_i, ss_load_i, sti_i} = 5'h00;
      repeat (3) @(negedge clk_i);
   end
   endtask
   task automatic took(input int n);
   begin
      chk("take count", 8'(n), 8'(takes - t0));
      t0 = takes;
   end
   endtask
   // Bounded wait until the entry sequence has run out
   task automatic settle();
      int i;
   begin
      for (i = 0; i < 40 && (save_state_o | ack_cycle_o | take_o) !== 1'b0; i++)
         @(negedge clk_i);
      repeat (2) @(negedge clk_i);
   end
   endtask
   // Bus side: random stalls before each save or acknowledge cycle ends
   always @(negedge clk_i)
   begin
      cycle_done_i <= 1'b0;
      if ((save_state_o | ack_cycle_o) === 1'b1 && cycle_done_i !== 1'b1 && $urandom_range(1, 0) == 1)
         cycle_done_i <= 1'b1;
   end
   // Monitor: counts takes, saves and acknowledge cycles, checks every vector
   always @(posedge clk_i)
   begin
      if (take_o === 1'b1)
         takes++;
      if (save_state_o === 1'b1 && cycle_done_i === 1'b1)
         saves++;
      if (ack_cycle_o === 1'b1 && cycle_done_i === 1'b1)
         acks++;
      if (vec_valid_o === 1'b1)
      begin
         vecs++;
         chk("vector", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, vector_o);
         chk("saves before vector", 8'(vecs), 8'(saves));
      end
   end
   // Watchdog, far beyond the few hundred cycles needed
   initial
   begin
      #(50 * 20000);
      fail_count++;
      close_out();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      // Coprocessor wait idles high; the bus side alone drives cycle done
      {nrst_i, bus_request_i, cop_wait_n_i, if_flag_i, data_low_i} = 12'h200;
      {interrupt_return_instruction_i, boundary_i, string_iter_i, ss_load_i, sti_i} = 5'h00;
      {fail_count, samples_checked, takes, acks, saves, vecs, t0} = '0;
      void'($urandom(40));
      repeat (6) @(negedge clk_i);
      nrst_i = 1'b1;
      repeat (3) @(negedge clk_i);
      // Unmasked edge with the flag clear, no acknowledge cycles
      a0 = acks;
      exp_q.push_back(8'h02);
      src_u.nmi_edge();
      step(5'h08);
      settle();
      took(1);
      chk("ack count", 8'h00, 8'(acks - a0));
      // Two edges in service: blocked, exactly one kept
      src_u.nmi_edge();
      src_u.nmi_edge();
      step(5'h08);
      took(0);
      exp_q.push_back(8'h02);
      step(5'h10);
      step(5'h08);
      settle();
      step(5'h10);
      step(5'h08);
      took(1);
      // Masked level, then enabled with a random vector
      data_low_i = 8'($urandom);
      src_u.mreq_o = 1'b1;
      step(5'h08);
      step(5'h08);
      took(0);
      if_flag_i = 1'b1;
      a0 = acks;
      exp_q.push_back(data_low_i);
      step(5'h08);
      settle();
      took(1);
      chk("ack count", 8'h02, 8'(acks - a0));
      // Stack segment load and flag set both defer by one instruction
      for (k = 0; k < 2; k++)
      begin
         src_u.mreq_o = 1'b1;
         data_low_i = 8'($urandom);
         exp_q.push_back(data_low_i);
         repeat (4) @(negedge clk_i);
         step(k == 0 ? 5'h0a : 5'h09);
         took(0);
         // An iteration inside the following instruction stays shadowed
         step(5'h04);
         took(0);
         step(5'h08);
         settle();
         took(1);
      end
      // Between string iterations
      src_u.mreq_o = 1'b1;
      exp_q.push_back(data_low_i);
      repeat (4) @(negedge clk_i);
      step(5'h04);
      settle();
      took(1);
      // Edge during bus grant is held until release
      bus_request_i = 1'b1;
      repeat (4) @(negedge clk_i);
      chk("grant", 8'h01, 8'(grant_o));
      src_u.nmi_edge();
      step(5'h08);
      took(0);
      bus_request_i = 1'b0;
      exp_q.push_back(8'h02);
      repeat (4) @(negedge clk_i);
      step(5'h08);
      settle();
      took(1);
      step(5'h10);
      // Reset over grant, pending edge cleared, self-test by wait level
      for (j = 0; j < 2; j++)
      begin
         src_u.nmi_edge();
         exp_q.push_back(8'h02);
         step(5'h08);
         settle();
         src_u.nmi_edge();
         bus_request_i = 1'b1;
         cop_wait_n_i = j[0];
         repeat (4) @(negedge clk_i);
         src_u.pulse_reset(j == 0 ? 80 : 15);
         chk("in reset", 8'h01, 8'(in_reset_o));
         chk("grant", 8'h00, 8'(grant_o));
         bus_request_i = 1'b0;
         repeat (6) @(negedge clk_i);
         chk("self test", 8'(j == 0), 8'(selftest_o));
         t0 = takes;
         step(5'h08);
         took(0);
         src_u.nmi_edge();
         exp_q.push_back(8'h02);
         step(5'h08);
         settle();
         took(1);
         step(5'h10);
      end
      chk("vectors left", 8'h00, 8'(exp_q.size()));
      close_out();
   end
endmodule
